// *** exec_pkg.sv ***
// Notes on behaviour
// - a load copies the operand byte into accumulator, x or y by opcode
// - a loaded register holds its byte until rewritten; memory is not touched
// - immediate loads take the operand byte itself instead of reading memory
// - a store writes a, x or y to memory; the register keeps its value
// - stores have no immediate form; decoder rejects it
// - memory increment reads the byte, adds one, writes back to same place
// - increments wrap within eight bits, 255 becomes 0, no carry out
// - x and y increments are implied, no operand, act on the register
// - memory increment supports zero page and full 16-bit absolute address
// - decrements mirror increments: minus one, same modes and wraparound
// - compares subtract memory from register and change only flags
// - the three compares use accumulator, x and y respectively
// - compares accept immediate, zero page and absolute operands
// - arithmetic and logic results go to the accumulator only
// - add with carry puts accumulator plus operand plus carry in accumulator
// - subtract takes operand and inverted carry from the accumulator
// - logic ops combine accumulator and operand by and, or, exclusive or
// - bit test copies operand bit 7 to negative, bit 6 to overflow
// - bit test sets zero from accumulator and operand; accumulator unchanged
`default_nettype none
package exec_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_OPND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_XR = 8'h0c;
  localparam logic [7:0] OFF_YR = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_MODE_LSB = 8;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;
  localparam logic [7:0] FLAG_MASK = 8'hc3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILLEGAL = 1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ZP_HIGH = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IMMEDIATE = 2'h0,
    MODE_ZERO_PAGE = 2'h1,
    MODE_ABSOLUTE = 2'h2,
    MODE_RESERVED = 2'h3
  } mode_t;
  typedef enum logic [4:0] {
    OP_LOAD_ACCUMULATOR = 5'h00, OP_LOAD_X_INDEX = 5'h01, OP_LOAD_Y_INDEX = 5'h02,
    OP_STORE_ACCUMULATOR = 5'h03, OP_STORE_X_INDEX = 5'h04, OP_STORE_Y_INDEX = 5'h05,
    OP_BUMP_MEMORY = 5'h06, OP_LOWER_MEMORY_BY_ONE = 5'h07,
    OP_BUMP_X_INDEX = 5'h08, OP_LOWER_X_INDEX = 5'h09,
    OP_BUMP_Y_INDEX = 5'h0a, OP_LOWER_Y_INDEX = 5'h0b,
    OP_COMPARE_ACCUMULATOR = 5'h0c, OP_COMPARE_X_INDEX = 5'h0d, OP_COMPARE_Y_INDEX = 5'h0e,
    OP_ADD_WITH_CARRY = 5'h0f, OP_SUBTRACT_WITH_BORROW = 5'h10,
    OP_AND_WITH_ACCUMULATOR = 5'h11, OP_OR_WITH_ACCUMULATOR = 5'h12,
    OP_EXCLUSIVE_OR_WITH_ACCUMULATOR = 5'h13, OP_BIT_TEST = 5'h14
  } op_t;
  typedef enum logic [2:0] {
    SEL_ACC = 3'h0, SEL_X = 3'h1, SEL_Y = 3'h2, SEL_MEM = 3'h3, SEL_NONE = 3'h4
  } sel_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_READ = 5'h04, ST_EXEC = 5'h08, ST_WRITE = 5'h10
  } state_t;
endpackage : exec_pkg
`default_nettype wire

// *** exec_if.sv ***
`default_nettype none
// ----------------------------------------------------------------
// alu operands and results
// ----------------------------------------------------------------
interface alu_if;
  exec_pkg::op_t op;
  logic [7:0] a;
  logic [7:0] m;
  logic c_in;
  logic [7:0] res;
  logic n, v, z, c;
  logic we_nz, we_v, we_c;
  modport core (output op, a, m, c_in, input res, n, v, z, c, we_nz, we_v, we_c);
  modport unit (input op, a, m, c_in, output res, n, v, z, c, we_nz, we_v, we_c);
endinterface : alu_if

// ----------------------------------------------------------------
// decoded command
// ----------------------------------------------------------------
interface dec_if;
  exec_pkg::op_t op;
  exec_pkg::mode_t mode;
  exec_pkg::sel_t src, dst;
  logic rd_mem, wr_mem, legal;
  modport core (output op, mode, input src, dst, rd_mem, wr_mem, legal);
  modport unit (input op, mode, output src, dst, rd_mem, wr_mem, legal);
endinterface : dec_if
`default_nettype wire

// *** alu_unit.sv ***
`default_nettype none
module alu_unit (
  alu_if.unit u
);
  logic [8:0] sum;
  logic [7:0] opb;

  // result and flag updates per operation
  always_comb begin
    sum = 9'h000;
    opb = u.m;
    u.res = u.a;
    u.v = 1'b0;
    u.c = 1'b0;
    u.we_nz = 1'b1;
    u.we_v = 1'b0;
    u.we_c = 1'b0;
    case (u.op)
      exec_pkg::OP_LOAD_ACCUMULATOR, exec_pkg::OP_LOAD_X_INDEX,
      exec_pkg::OP_LOAD_Y_INDEX: u.res = u.m;
      exec_pkg::OP_STORE_ACCUMULATOR, exec_pkg::OP_STORE_X_INDEX,
      exec_pkg::OP_STORE_Y_INDEX: u.we_nz = 1'b0;
      exec_pkg::OP_BUMP_MEMORY, exec_pkg::OP_BUMP_X_INDEX,
      exec_pkg::OP_BUMP_Y_INDEX: u.res = u.a + exec_pkg::BYTE_ONE; // 8-bit wrap
      exec_pkg::OP_LOWER_MEMORY_BY_ONE, exec_pkg::OP_LOWER_X_INDEX,
      exec_pkg::OP_LOWER_Y_INDEX: u.res = u.a - exec_pkg::BYTE_ONE;
      exec_pkg::OP_COMPARE_ACCUMULATOR, exec_pkg::OP_COMPARE_X_INDEX,
      exec_pkg::OP_COMPARE_Y_INDEX: begin
        // borrow-free subtract: carry out means register >= memory
        sum = {1'b0, u.a} + {1'b0, ~u.m} + 9'h001;
        u.res = sum[7:0];
        u.c = sum[8];
        u.we_c = 1'b1;
      end
      exec_pkg::OP_ADD_WITH_CARRY, exec_pkg::OP_SUBTRACT_WITH_BORROW: begin
        // subtract adds the complement; carry in is the inverted borrow
        if (u.op == exec_pkg::OP_SUBTRACT_WITH_BORROW) begin
          opb = ~u.m;
        end
        sum = {1'b0, u.a} + {1'b0, opb} + {8'h00, u.c_in};
        u.res = sum[7:0];
        u.c = sum[8];
        u.v = (u.a[7] == opb[7]) && (sum[7] != u.a[7]);
        u.we_c = 1'b1;
        u.we_v = 1'b1;
      end
      exec_pkg::OP_AND_WITH_ACCUMULATOR: u.res = u.a & u.m;
      exec_pkg::OP_OR_WITH_ACCUMULATOR: u.res = u.a | u.m;
      exec_pkg::OP_EXCLUSIVE_OR_WITH_ACCUMULATOR: u.res = u.a ^ u.m;
      exec_pkg::OP_BIT_TEST: begin
        u.res = u.a & u.m;
        u.v = u.m[6];
        u.we_v = 1'b1;
      end
      default: u.we_nz = 1'b0;
    endcase
    u.z = (u.res == exec_pkg::BYTE_RESET);
    u.n = (u.op == exec_pkg::OP_BIT_TEST) ? u.m[7] : u.res[7];
  end
endmodule : alu_unit
`default_nettype wire

// *** op_decoder.sv ***
`default_nettype none
module op_decoder (
  dec_if.unit d
);
  // implied ops ignore the mode field entirely
  function automatic logic is_implied(input exec_pkg::op_t op);
    return op inside {exec_pkg::OP_BUMP_X_INDEX, exec_pkg::OP_LOWER_X_INDEX,
                      exec_pkg::OP_BUMP_Y_INDEX, exec_pkg::OP_LOWER_Y_INDEX};
  endfunction : is_implied

  // ops that write memory cannot take a constant operand
  function automatic logic writes_mem(input exec_pkg::op_t op);
    return op inside {exec_pkg::OP_STORE_ACCUMULATOR, exec_pkg::OP_STORE_X_INDEX,
                      exec_pkg::OP_STORE_Y_INDEX, exec_pkg::OP_BUMP_MEMORY,
                      exec_pkg::OP_LOWER_MEMORY_BY_ONE};
  endfunction : writes_mem

  // sources, destinations and memory traffic
  always_comb begin
    d.src = exec_pkg::SEL_ACC;
    d.dst = exec_pkg::SEL_NONE;
    case (d.op)
      exec_pkg::OP_LOAD_ACCUMULATOR: d.dst = exec_pkg::SEL_ACC;
      exec_pkg::OP_LOAD_X_INDEX: d.dst = exec_pkg::SEL_X;
      exec_pkg::OP_LOAD_Y_INDEX: d.dst = exec_pkg::SEL_Y;
      exec_pkg::OP_STORE_ACCUMULATOR: d.dst = exec_pkg::SEL_MEM;
      exec_pkg::OP_STORE_X_INDEX: begin
        d.src = exec_pkg::SEL_X;
        d.dst = exec_pkg::SEL_MEM;
      end
      exec_pkg::OP_STORE_Y_INDEX: begin
        d.src = exec_pkg::SEL_Y;
        d.dst = exec_pkg::SEL_MEM;
      end
      exec_pkg::OP_BUMP_MEMORY, exec_pkg::OP_LOWER_MEMORY_BY_ONE: begin
        d.src = exec_pkg::SEL_MEM;
        d.dst = exec_pkg::SEL_MEM;
      end
      exec_pkg::OP_BUMP_X_INDEX, exec_pkg::OP_LOWER_X_INDEX: begin
        d.src = exec_pkg::SEL_X;
        d.dst = exec_pkg::SEL_X;
      end
      exec_pkg::OP_BUMP_Y_INDEX, exec_pkg::OP_LOWER_Y_INDEX: begin
        d.src = exec_pkg::SEL_Y;
        d.dst = exec_pkg::SEL_Y;
      end
      exec_pkg::OP_COMPARE_X_INDEX: d.src = exec_pkg::SEL_X;
      exec_pkg::OP_COMPARE_Y_INDEX: d.src = exec_pkg::SEL_Y;
      exec_pkg::OP_COMPARE_ACCUMULATOR, exec_pkg::OP_BIT_TEST: d.dst = exec_pkg::SEL_NONE;
      exec_pkg::OP_ADD_WITH_CARRY, exec_pkg::OP_SUBTRACT_WITH_BORROW, exec_pkg::OP_AND_WITH_ACCUMULATOR,
      exec_pkg::OP_OR_WITH_ACCUMULATOR, exec_pkg::OP_EXCLUSIVE_OR_WITH_ACCUMULATOR:
        d.dst = exec_pkg::SEL_ACC;
      default: d.dst = exec_pkg::SEL_NONE;
    endcase
  end

  // legality: stores and memory counters refuse the constant form
  assign d.legal = (d.op <= exec_pkg::OP_BIT_TEST) &&
                   (is_implied(d.op) || (d.mode != exec_pkg::MODE_RESERVED &&
                   !(writes_mem(d.op) && d.mode == exec_pkg::MODE_IMMEDIATE)));
  assign d.wr_mem = writes_mem(d.op);
  assign d.rd_mem = !is_implied(d.op) && d.mode != exec_pkg::MODE_IMMEDIATE &&
                    !(d.dst == exec_pkg::SEL_MEM && d.src != exec_pkg::SEL_MEM);
endmodule : op_decoder
`default_nettype wire

// *** exec_core.sv ***
// The implementer's own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module exec_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [exec_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_pkg::state_t state_reg, state_next;
  exec_pkg::op_t op_reg, op_next;
  exec_pkg::mode_t mode_reg, mode_next;
  logic [15:0] opnd_reg, opnd_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] x_reg, x_next;
  logic [7:0] y_reg, y_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] mdata_reg, mdata_next;
  logic [7:0] wdata_reg, wdata_next;
  logic illegal_reg, illegal_next;
  logic [31:0] prdata_reg, prdata_next;
  logic busy;
  logic setup_rd;
  logic acc_wr;
  logic refused;

  alu_if alu ();
  dec_if dec ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true for every mapped word
  function automatic logic reg_known(input logic [exec_pkg::APB_ADDR_W-1:0] a);
    return a inside {exec_pkg::OFF_CMD, exec_pkg::OFF_OPND, exec_pkg::OFF_ACC, exec_pkg::OFF_XR,
                     exec_pkg::OFF_YR, exec_pkg::OFF_FLAGS, exec_pkg::OFF_STAT};
  endfunction : reg_known

  // true for words that software may write
  function automatic logic reg_writable(input logic [exec_pkg::APB_ADDR_W-1:0] a);
    return reg_known(a) && a != exec_pkg::OFF_STAT;
  endfunction : reg_writable

  // ----------------------------------------------------------------
  // decoder and alu
  // ----------------------------------------------------------------
  assign dec.op = op_reg;
  assign dec.mode = mode_reg;

  op_decoder u_dec (
    .d(dec.unit)
  );

  // the alu sees the register or memory byte that the decoder picks
  always_comb begin
    alu.op = op_reg;
    alu.m = mdata_reg;
    alu.c_in = flags_reg[exec_pkg::FLAG_C];
    case (dec.src)
      exec_pkg::SEL_X: alu.a = x_reg;
      exec_pkg::SEL_Y: alu.a = y_reg;
      exec_pkg::SEL_MEM: alu.a = mdata_reg;
      default: alu.a = acc_reg;
    endcase
  end

  alu_unit u_alu (
    .u(alu.unit)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign busy = (state_reg != exec_pkg::ST_IDLE);
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  // writes to a busy core would race the running op, so they bounce
  assign refused = acc_wr && busy && reg_writable(paddr);
  // zero wait states: read data is caught in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!reg_known(paddr) || refused);
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  assign mem_req = (state_reg == exec_pkg::ST_READ) || (state_reg == exec_pkg::ST_WRITE);
  assign mem_we = (state_reg == exec_pkg::ST_WRITE);
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // registers hold unless the bus or the sequencer writes them
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    mode_next = mode_reg;
    opnd_next = opnd_reg;
    addr_next = addr_reg;
    acc_next = acc_reg;
    x_next = x_reg;
    y_next = y_reg;
    flags_next = flags_reg;
    mdata_next = mdata_reg;
    wdata_next = wdata_reg;
    illegal_next = illegal_reg;
    prdata_next = prdata_reg;

    // read mux, unmapped words read as zero
    if (setup_rd) begin
      case (paddr)
        exec_pkg::OFF_CMD: prdata_next = {22'h0, mode_reg, 3'h0, op_reg};
        exec_pkg::OFF_OPND: prdata_next = {16'h0000, opnd_reg};
        exec_pkg::OFF_ACC: prdata_next = {24'h000000, acc_reg};
        exec_pkg::OFF_XR: prdata_next = {24'h000000, x_reg};
        exec_pkg::OFF_YR: prdata_next = {24'h000000, y_reg};
        exec_pkg::OFF_FLAGS: prdata_next = {24'h000000, flags_reg};
        exec_pkg::OFF_STAT: prdata_next = {30'h0, illegal_reg, busy};
        default: prdata_next = 32'h00000000;
      endcase
    end

    // software writes, only while idle
    if (acc_wr && !busy) begin
      case (paddr)
        exec_pkg::OFF_CMD: begin
          op_next = exec_pkg::op_t'(pwdata[exec_pkg::CMD_OP_LSB +: 5]);
          mode_next = exec_pkg::mode_t'(pwdata[exec_pkg::CMD_MODE_LSB +: 2]);
          state_next = exec_pkg::ST_START;
        end
        exec_pkg::OFF_OPND: opnd_next = pwdata[15:0];
        exec_pkg::OFF_ACC: acc_next = pwdata[7:0];
        exec_pkg::OFF_XR: x_next = pwdata[7:0];
        exec_pkg::OFF_YR: y_next = pwdata[7:0];
        exec_pkg::OFF_FLAGS: flags_next = pwdata[7:0] & exec_pkg::FLAG_MASK;
        default: flags_next = flags_reg;
      endcase
    end

    // sequencer
    case (state_reg)
      exec_pkg::ST_IDLE: ;
      exec_pkg::ST_START: begin
        // effective address: zero page or full 16-bit absolute
        if (mode_reg == exec_pkg::MODE_ZERO_PAGE) begin
          addr_next = {exec_pkg::ZP_HIGH, opnd_reg[7:0]};
        end else begin
          addr_next = opnd_reg;
        end
        mdata_next = opnd_reg[7:0]; // constant operand
        illegal_next = !dec.legal;
        if (!dec.legal) begin
          state_next = exec_pkg::ST_IDLE;
        end else if (dec.rd_mem) begin
          state_next = exec_pkg::ST_READ;
        end else begin
          state_next = exec_pkg::ST_EXEC;
        end
      end
      exec_pkg::ST_READ: begin
        if (mem_ack) begin
          mdata_next = mem_rdata;
          state_next = exec_pkg::ST_EXEC;
        end
      end
      exec_pkg::ST_EXEC: begin
        // commit result and flags; compares and bit test have no destination
        case (dec.dst)
          exec_pkg::SEL_ACC: acc_next = alu.res;
          exec_pkg::SEL_X: x_next = alu.res;
          exec_pkg::SEL_Y: y_next = alu.res;
          default: acc_next = acc_reg;
        endcase
        if (alu.we_nz) begin
          flags_next[exec_pkg::FLAG_N] = alu.n;
          flags_next[exec_pkg::FLAG_Z] = alu.z;
        end
        if (alu.we_v) begin
          flags_next[exec_pkg::FLAG_V] = alu.v;
        end
        if (alu.we_c) begin
          flags_next[exec_pkg::FLAG_C] = alu.c;
        end
        wdata_next = alu.res; // register copied, not moved
        state_next = dec.wr_mem ? exec_pkg::ST_WRITE : exec_pkg::ST_IDLE;
      end
      exec_pkg::ST_WRITE: begin
        // write lands at the effective address; an increment or decrement read that same address first
        if (mem_ack) begin
          state_next = exec_pkg::ST_IDLE;
        end
      end
      default: state_next = exec_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all control state returns to constants under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= exec_pkg::ST_IDLE;
      op_reg <= exec_pkg::OP_LOAD_ACCUMULATOR;
      mode_reg <= exec_pkg::MODE_IMMEDIATE;
      opnd_reg <= exec_pkg::WORD_RESET;
      addr_reg <= exec_pkg::WORD_RESET;
      acc_reg <= exec_pkg::BYTE_RESET;
      x_reg <= exec_pkg::BYTE_RESET;
      y_reg <= exec_pkg::BYTE_RESET;
      flags_reg <= exec_pkg::BYTE_RESET;
      mdata_reg <= exec_pkg::BYTE_RESET;
      wdata_reg <= exec_pkg::BYTE_RESET;
      illegal_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      mode_reg <= mode_next;
      opnd_reg <= opnd_next;
      addr_reg <= addr_next;
      acc_reg <= acc_next;
      x_reg <= x_next;
      y_reg <= y_next;
      flags_reg <= flags_next;
      mdata_reg <= mdata_next;
      wdata_reg <= wdata_next;
      illegal_reg <= illegal_next;
      prdata_reg <= prdata_next;
    end
  end
endmodule : exec_core
`default_nettype wire

// *** exec_core_chk.sv ***
`default_nettype none
module exec_core_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [exec_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // memory side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // memory access steps
  // --------------------------------------------------------------
  sequence rd_done_s;
    mem_req && !mem_we && mem_ack;
  endsequence
  sequence rmw_s;
    rd_done_s ##2 mem_we;
  endsequence
  // accepted store command with a constant operand
  sequence store_imm_s;
    psel && penable && pwrite && paddr == exec_pkg::OFF_CMD && !pslverr &&
      pwdata[4:0] inside {5'h03, 5'h04, 5'h05} && pwdata[9:8] == 2'h0;
  endsequence
  we_has_req_a: assert property (mem_we |-> mem_req) else $error("write strobe without request");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before answer");
  wdata_hold_a: assert property (mem_we && !mem_ack |=> $stable(mem_wdata))
    else $error("write data changed before answer");
  // the write-back must go to the byte just read, off by exactly one
  rmw_step_a: assert property (rmw_s |-> mem_addr == $past(mem_addr, 2) &&
    (mem_wdata == $past(mem_rdata, 2) + 8'h01 || mem_wdata == $past(mem_rdata, 2) - 8'h01))
    else $error("write-back is not read value plus or minus one");
  store_imm_a: assert property (store_imm_s |=> !mem_req [*4]) else $error("constant store touched memory");
  ack_ends_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("request outlived its answer");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access phase");
  unmapped_err_a: assert property (psel && penable && paddr > exec_pkg::OFF_STAT |-> pslverr)
    else $error("unmapped access without error");
endmodule : exec_core_chk

bind exec_core exec_core_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
`default_nettype wire

// *** mem_model.sv ***
`default_nettype none
module mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory bus from the core
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  // wait states before each answer
  input wire logic [3:0] wait_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [0:65535];
  logic [3:0] cnt;
  // data lines toggle between answers so a stale byte never passes for a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack) begin
        cnt <= 4'h0;
        if (mem_we) ram[mem_addr] <= mem_wdata;
      end else if (mem_req && cnt >= wait_cycles) begin
        mem_ack <= 1'b1;
        if (!mem_we) mem_rdata <= ram[mem_addr];
      end else if (mem_req) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, err;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] mem_addr;
  logic [3:0] wait_cycles;
  int num_errors = 0;
  int total_checks = 0;
  typedef struct {logic [4:0] op; logic [1:0] md; logic [7:0] r, f, m, tgt, er, ef, em;} row_t;
  // op, mode, regs in, flags in, operand, target, target out, flags out, memory out
  row_t rows [24] = '{
    '{5'h00,2'h0,8'h11,8'h00,8'h80,8'h08,8'h80,8'h80,8'h80}, '{5'h01,2'h1,8'h11,8'hc3,8'h00,8'h0c,8'h00,8'h43,8'h00},
    '{5'h02,2'h2,8'h11,8'h00,8'h7f,8'h10,8'h7f,8'h00,8'h7f}, '{5'h03,2'h2,8'h5a,8'h00,8'h00,8'h08,8'h5a,8'h00,8'h5a},
    '{5'h04,2'h1,8'ha5,8'h00,8'h00,8'h0c,8'ha5,8'h00,8'ha5}, '{5'h05,2'h2,8'h3c,8'h00,8'h00,8'h10,8'h3c,8'h00,8'h3c},
    '{5'h06,2'h2,8'h00,8'h00,8'hff,8'h08,8'h00,8'h02,8'h00}, '{5'h07,2'h1,8'h00,8'h00,8'h00,8'h08,8'h00,8'h80,8'hff},
    '{5'h08,2'h0,8'hff,8'h00,8'h00,8'h0c,8'h00,8'h02,8'h00}, '{5'h09,2'h0,8'h01,8'h00,8'h00,8'h0c,8'h00,8'h02,8'h00},
    '{5'h0a,2'h0,8'h7f,8'h00,8'h00,8'h10,8'h80,8'h80,8'h00}, '{5'h0b,2'h0,8'h00,8'h00,8'h00,8'h10,8'hff,8'h80,8'h00},
    '{5'h0c,2'h0,8'h40,8'h00,8'h40,8'h08,8'h40,8'h03,8'h40}, '{5'h0d,2'h1,8'h10,8'h00,8'h20,8'h0c,8'h10,8'h80,8'h20},
    '{5'h0e,2'h2,8'h80,8'h00,8'h01,8'h10,8'h80,8'h01,8'h01}, '{5'h0f,2'h0,8'h50,8'h01,8'h10,8'h08,8'h61,8'h00,8'h10},
    '{5'h0f,2'h2,8'h50,8'h00,8'h50,8'h08,8'ha0,8'hc0,8'h50}, '{5'h10,2'h0,8'h50,8'h00,8'h10,8'h08,8'h3f,8'h01,8'h10},
    '{5'h10,2'h1,8'h42,8'h01,8'h42,8'h08,8'h00,8'h03,8'h42}, '{5'h11,2'h2,8'hf2,8'h00,8'h8a,8'h08,8'h82,8'h80,8'h8a},
    '{5'h12,2'h1,8'h83,8'h00,8'ha9,8'h08,8'hab,8'h80,8'ha9}, '{5'h13,2'h0,8'h83,8'h00,8'ha9,8'h08,8'h2a,8'h00,8'ha9},
    '{5'h14,2'h2,8'hcd,8'h00,8'ha9,8'h08,8'hcd,8'h80,8'ha9}, '{5'h14,2'h1,8'h84,8'h01,8'h7a,8'h08,8'h84,8'h43,8'h7a}};
  exec_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  mem_model mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .wait_cycles);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // one idle cycle after each transfer keeps a signal from being driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // poke tries an accumulator write while the command is still running
  task automatic run(input logic [4:0] op, input logic [1:0] md, input logic [15:0] opnd,
                     input logic poke = 1'b0);
    int n;
    n = 0;
    apb(1'b1, exec_pkg::OFF_OPND, {16'h0000, opnd}, q);
    apb(1'b1, exec_pkg::OFF_CMD, {22'h000000, md, 3'h0, op}, q);
    if (poke) begin apb(1'b1, exec_pkg::OFF_ACC, 32'h000000ff, q); `CHK(err, 1'b1) end
    q = 32'h00000001;
    while (q[exec_pkg::STAT_BUSY] !== 1'b0 && n < 100) begin apb(1'b0, exec_pkg::OFF_STAT, 32'h0, q); n++; end
    if (n >= 100) num_errors++;
  endtask : run
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
  // a hung handshake ends the run here
  initial begin repeat (30000) @(posedge pclk); num_errors++; give_verdict(); end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wait_cycles} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 5; k++) begin apb(1'b0, 8'(8 + 4 * k), 32'h0, q); `CHK(q, 32'h0) end
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      mem.ram[16'h2000] = rows[i].m;
      mem.ram[16'h00fb] = rows[i].m;
      for (int k = 0; k < 3; k++) apb(1'b1, 8'(8 + 4 * k), {24'h0, rows[i].r}, q);
      apb(1'b1, exec_pkg::OFF_FLAGS, {24'h0, rows[i].f}, q); // carry preset per row
      run(rows[i].op, rows[i].md, rows[i].md == 2'h0 ? {8'h00, rows[i].m} : rows[i].md == 2'h1 ? 16'h00fb : 16'h2000);
      for (int k = 0; k < 3; k++) begin
        apb(1'b0, 8'(8 + 4 * k), 32'h0, q);
        `CHK(q[7:0], 8'(8 + 4 * k) == rows[i].tgt ? rows[i].er : rows[i].r)
      end
      apb(1'b0, exec_pkg::OFF_FLAGS, 32'h0, q);
      `CHK(q[7:0], rows[i].ef)
      `CHK(mem.ram[rows[i].md == 2'h1 ? 16'h00fb : 16'h2000], rows[i].em)
      $display("row %0d done", i);
    end
    // constant stores and a reserved mode are refused and leave memory alone
    mem.ram[16'h2000] = 8'h11;
    for (int k = 0; k < 4; k++) begin
      run(k == 3 ? 5'h0c : 5'(3 + k), k == 3 ? 2'h3 : 2'h0, 16'h2000);
      apb(1'b0, exec_pkg::OFF_STAT, 32'h0, q);
      `CHK(q[1:0], 2'h2)
      `CHK(mem.ram[16'h2000], 8'h11)
    end
    $display("refusal test done");
    apb(1'b0, 8'h1c, 32'h0, q);
    `CHK({err, q}, {1'b1, 32'h0})
    // slow memory on a full-address increment; a write while busy must bounce
    wait_cycles <= 4'h3;
    mem.ram[16'h8123] = 8'h7f;
    run(5'h06, 2'h2, 16'h8123, 1'b1);
    `CHK(mem.ram[16'h8123], 8'h80)
    apb(1'b0, exec_pkg::OFF_ACC, 32'h0, q);
    `CHK(q[7:0], rows[23].r)
    $display("slow memory test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
